// ### hw/spg_pkg.sv
// How it works
// - single or double pulse state is combined freely with internal or external triggering.
// - the internal repetition period is held between 1 us and 100 ms.
// - the video pulse width is held between 50 ns and 100 ms.
// - the delay from cycle start to the video pulse is held between 500 ns and 100 ms.
// - the delay between the two double pulses is held between 100 ns and 100 ms.
// - every timing value is a whole number of 50 ns steps.
// - each cycle drives a sync pulse 400 ns long.
// - the sync onset starts the cycle and the pulse delay counts from it; the double pulse delay counts from the first video onset.
// - in external mode a rising trigger input starts a cycle timed from that edge.
// - with pulse modulation on, the modulator takes the video or the raw trigger input.
// - reset leaves single pulse state with internal triggering.
// - in internal mode a period below delay plus width, plus double pulse delay in double state, makes the setting invalid.
// - in double state a double pulse delay below the width makes the setting invalid.
// - while invalid the error flag is up and video stays low.
// - with the video as modulator source, the modulator drive switches in the same cycle as the video output.
// - separate toggles flip the pulse state and the trigger mode.
package spg_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 50;
  localparam int SYNC_NS = 400;
  localparam int SYNC_TICKS = SYNC_NS / TICK_NS;
  localparam int MIN_PER_NS = 1000;
  localparam int MIN_WID_NS = 50;
  localparam int MIN_DLY_NS = 500;
  localparam int MIN_DD_NS = 100;
  localparam int MAX_NS = 100000000;
  localparam int CW = 21;
  typedef logic [CW-1:0] spg_cnt_t;
  localparam spg_cnt_t MAX_TICKS = CW'(MAX_NS / TICK_NS);
  localparam spg_cnt_t MIN_PER = CW'(MIN_PER_NS / TICK_NS);
  localparam spg_cnt_t MIN_WID = CW'(MIN_WID_NS / TICK_NS);
  localparam spg_cnt_t MIN_DLY = CW'(MIN_DLY_NS / TICK_NS);
  localparam spg_cnt_t MIN_DD = CW'(MIN_DD_NS / TICK_NS);
  localparam spg_cnt_t SYNC_CNT = CW'(SYNC_TICKS);
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PER = 8'h04;
  localparam logic [7:0] OFS_WID = 8'h08;
  localparam logic [7:0] OFS_DLY = 8'h0c;
  localparam logic [7:0] OFS_DD = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_TOG = 8'h18;
  localparam int CTRL_DBL = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_PM = 2;
  localparam int CTRL_SRC = 3;
  localparam spg_cnt_t RST_PER = 21'h000032;
  localparam spg_cnt_t RST_WID = 21'h000014;
  localparam spg_cnt_t RST_DLY = 21'h000014;
  localparam spg_cnt_t RST_DD = 21'h000032;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLV = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_DLY, ST_W1, ST_GAP, ST_W2} spg_state_e;
endpackage : spg_pkg

// ### hw/spg_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface spg_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface : spg_tick_if
`default_nettype wire

// ### hw/spg_timebase.sv
`timescale 1ns/100ps
`default_nettype none
module spg_timebase
  import spg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // tick out
  spg_tick_if.src tb
);
  // ------------------------------------------------------------
  // 50 ns tick from a 40 ns clock by phase accumulation
  // ------------------------------------------------------------
  logic [6:0] acc_ff;
  logic [6:0] nxt_acc;
  logic tick_ff;
  always_comb begin
    nxt_acc = acc_ff + 7'(CLK_NS);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff <= 7'h00;
      tick_ff <= 1'b0;
    end else if (nxt_acc >= 7'(TICK_NS)) begin
      acc_ff <= nxt_acc - 7'(TICK_NS);
      tick_ff <= 1'b1;
    end else begin
      acc_ff <= nxt_acc;
      tick_ff <= 1'b0;
    end
  end
  assign tb.tick = tick_ff;
endmodule : spg_timebase
`default_nettype wire

// ### hw/spg_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none
module spg_pulse_gen
  import spg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // pins
  input wire logic trig_i,
  output logic sync_o,
  output logic video_o,
  output logic mod_o,
  output logic err_o
);
  // ------------------------------------------------------------
  // timebase
  // ------------------------------------------------------------
  spg_tick_if tk ();
  spg_timebase u_tb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tb (tk.src)
  );
  logic tick;
  assign tick = tk.tick;

  // ------------------------------------------------------------
  // axi4-lite handshakes
  // ------------------------------------------------------------
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_hold_ff, w_hold_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic aw_hs, w_hs, ar_hs, do_wr;
  logic nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid;
  assign aw_hs = s_axi_awvalid_i & awready_ff;
  assign w_hs = s_axi_wvalid_i & wready_ff;
  assign ar_hs = s_axi_arvalid_i & arready_ff;
  assign do_wr = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign nxt_aw_hold = aw_hs | (aw_hold_ff & ~do_wr);
  assign nxt_w_hold = w_hs | (w_hold_ff & ~do_wr);
  assign nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready_i);
  assign nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
    end else begin
      awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
      wready_ff <= ~nxt_w_hold & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic dbl_ff, ext_ff, pm_ff, src_ff;
  spg_cnt_t per_ff, wid_ff, dly_ff, dd_ff;
  logic [31:0] wmask;
  logic wr_ctrl, wr_tog;
  logic wr_ok;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wr_ctrl = do_wr && awaddr_ff == OFS_CTRL;
  assign wr_tog = do_wr && awaddr_ff == OFS_TOG;
  assign wr_ok = awaddr_ff == OFS_CTRL || awaddr_ff == OFS_PER || awaddr_ff == OFS_WID
    || awaddr_ff == OFS_DLY || awaddr_ff == OFS_DD || awaddr_ff == OFS_TOG
    || awaddr_ff == OFS_STAT;

  function automatic spg_cnt_t clamp(input spg_cnt_t old, input logic [31:0] wd,
                                     input logic [31:0] m, input spg_cnt_t lo);
    logic [31:0] v;
    v = ({11'h000, old} & ~m) | (wd & m);
    if (v < {11'h000, lo}) begin
      return lo;
    end else if (v > {11'h000, MAX_TICKS}) begin
      return MAX_TICKS;
    end
    return v[CW-1:0];
  endfunction : clamp

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbl_ff <= 1'b0;
      ext_ff <= 1'b0;
      pm_ff <= 1'b0;
      src_ff <= 1'b0;
    end else if (wr_ctrl && wstrb_ff[0]) begin
      dbl_ff <= wdata_ff[CTRL_DBL];
      ext_ff <= wdata_ff[CTRL_EXT];
      pm_ff <= wdata_ff[CTRL_PM];
      src_ff <= wdata_ff[CTRL_SRC];
    end else if (wr_tog && wstrb_ff[0]) begin
      dbl_ff <= dbl_ff ^ wdata_ff[0];
      ext_ff <= ext_ff ^ wdata_ff[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_ff <= RST_PER;
      wid_ff <= RST_WID;
      dly_ff <= RST_DLY;
      dd_ff <= RST_DD;
    end else if (do_wr) begin
      if (awaddr_ff == OFS_PER) begin
        per_ff <= clamp(per_ff, wdata_ff, wmask, MIN_PER);
      end
      if (awaddr_ff == OFS_WID) begin
        wid_ff <= clamp(wid_ff, wdata_ff, wmask, MIN_WID);
      end
      if (awaddr_ff == OFS_DLY) begin
        dly_ff <= clamp(dly_ff, wdata_ff, wmask, MIN_DLY);
      end
      if (awaddr_ff == OFS_DD) begin
        dd_ff <= clamp(dd_ff, wdata_ff, wmask, MIN_DD);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bresp_ff <= RESP_OK;
    end else if (do_wr) begin
      bresp_ff <= wr_ok ? RESP_OK : RESP_SLV;
    end
  end

  // ------------------------------------------------------------
  // profile check
  // ------------------------------------------------------------
  logic [CW+1:0] need;
  logic bad_per, bad_dd, invalid;
  always_comb begin
    need = {2'b00, dly_ff} + {2'b00, wid_ff};
    if (dbl_ff) begin
      need = {2'b00, dly_ff} + {2'b00, dd_ff} + {2'b00, wid_ff};
    end
  end
  assign bad_per = ~ext_ff && {2'b00, per_ff} < need;
  assign bad_dd = dbl_ff && dd_ff < wid_ff;
  assign invalid = bad_per | bad_dd;

  // ------------------------------------------------------------
  // trigger input sync and edge
  // ------------------------------------------------------------
  logic [2:0] trs_ff;
  logic trig_lvl_ff;
  logic trig_rise;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trs_ff <= 3'h0;
      trig_lvl_ff <= 1'b0;
    end else begin
      trs_ff <= {trs_ff[1:0], trig_i};
      if (trs_ff[1] == trs_ff[2]) begin
        trig_lvl_ff <= trs_ff[2];
      end
    end
  end
  assign trig_rise = trs_ff[1] & trs_ff[2] & ~trig_lvl_ff;

  // ------------------------------------------------------------
  // cycle start and period counter
  // ------------------------------------------------------------
  spg_cnt_t per_cnt_ff;
  logic start;
  assign start = ext_ff ? trig_rise : (tick && per_cnt_ff <= CW'(1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_cnt_ff <= '0;
    end else if (start) begin
      per_cnt_ff <= per_ff;
    end else if (tick && per_cnt_ff != '0) begin
      per_cnt_ff <= per_cnt_ff - CW'(1);
    end
  end

  // ------------------------------------------------------------
  // sync pulse
  // ------------------------------------------------------------
  spg_cnt_t sync_cnt_ff;
  spg_cnt_t nxt_sync_cnt;
  always_comb begin
    nxt_sync_cnt = sync_cnt_ff;
    if (start) begin
      nxt_sync_cnt = SYNC_CNT;
    end else if (tick && sync_cnt_ff != '0) begin
      nxt_sync_cnt = sync_cnt_ff - CW'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_cnt_ff <= '0;
      sync_o <= 1'b0;
    end else begin
      sync_cnt_ff <= nxt_sync_cnt;
      sync_o <= nxt_sync_cnt != '0;
    end
  end

  // ------------------------------------------------------------
  // video sequencer
  // ------------------------------------------------------------
  spg_state_e st_ff, nxt_st;
  spg_cnt_t cnt_ff, nxt_cnt;
  logic done;
  assign done = tick && cnt_ff <= CW'(1);
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    if (tick && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CW'(1);
    end
    if (start) begin
      nxt_st = ST_DLY;
      nxt_cnt = dly_ff;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          nxt_cnt = '0;
        end
        ST_DLY: begin
          if (done) begin
            nxt_st = ST_W1;
            nxt_cnt = wid_ff;
          end
        end
        ST_W1: begin
          if (done && dbl_ff && dd_ff > wid_ff) begin
            nxt_st = ST_GAP;
            nxt_cnt = dd_ff - wid_ff;
          end else if (done && dbl_ff) begin
            nxt_st = ST_W2;
            nxt_cnt = wid_ff;
          end else if (done) begin
            nxt_st = ST_IDLE;
          end
        end
        ST_GAP: begin
          if (done) begin
            nxt_st = ST_W2;
            nxt_cnt = wid_ff;
          end
        end
        ST_W2: begin
          if (done) begin
            nxt_st = ST_IDLE;
          end
        end
        default: begin
          nxt_st = ST_IDLE;
          nxt_cnt = '0;
        end
      endcase
    end
  end

  logic nxt_video;
  assign nxt_video = (nxt_st == ST_W1 || nxt_st == ST_W2) && !invalid;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      video_o <= 1'b0;
      mod_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      video_o <= nxt_video;
      mod_o <= pm_ff && (src_ff ? trig_lvl_ff : nxt_video);
      err_o <= invalid;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OK;
    end else if (ar_hs) begin
      rresp_ff <= RESP_OK;
      case (s_axi_araddr_i)
        OFS_CTRL: rdata_ff <= {28'h0000000, src_ff, pm_ff, ext_ff, dbl_ff};
        OFS_PER: rdata_ff <= {11'h000, per_ff};
        OFS_WID: rdata_ff <= {11'h000, wid_ff};
        OFS_DLY: rdata_ff <= {11'h000, dly_ff};
        OFS_DD: rdata_ff <= {11'h000, dd_ff};
        OFS_STAT: rdata_ff <= {28'h0000000, st_ff != ST_IDLE, sync_o, video_o, err_o};
        OFS_TOG: rdata_ff <= 32'h0000_0000;
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_SLV;
        end
      endcase
    end
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sync_rise;
    $rose(sync_o);
  endsequence
  sequence s_sync_body;
    sync_o[*8] ##[1:4] !sync_o;
  endsequence
  sequence s_ext_start;
    ext_ff && trig_rise;
  endsequence

  a_sync_fixed_len: assert property (s_sync_rise |-> s_sync_body)
    else $error("sync pulse length wrong");
  a_sync_no_video: assert property (sync_o |-> !video_o)
    else $error("video high during sync");
  a_ext_trig_start: assert property (s_ext_start |=> nxt_sync_cnt == SYNC_CNT - CW'(tick) || sync_o)
    else $error("external trigger did not start a cycle");
  a_err_video_off: assert property (err_o |-> !video_o)
    else $error("video active while profile invalid");
  a_period_check: assert property (!ext_ff && {2'b00, per_ff} < {2'b00, dly_ff} + {2'b00, wid_ff} |=> err_o)
    else $error("short period not flagged");
  a_dd_check: assert property (dbl_ff && dd_ff < wid_ff |=> err_o)
    else $error("short double delay not flagged");
  a_mod_tracks: assert property (pm_ff && !src_ff && $stable(pm_ff) && $stable(src_ff) |=> mod_o == video_o)
    else $error("modulator drive not coincident with video");
  a_reset_mode: assert property ($past(rst_i) |-> !dbl_ff && !ext_ff)
    else $error("reset mode not single internal");
  a_toggle_state: assert property (wr_tog && wstrb_ff[0] && wdata_ff[0] |=> dbl_ff != $past(dbl_ff))
    else $error("pulse state toggle lost");
  a_period_range: assert property (per_ff >= MIN_PER && per_ff <= MAX_TICKS)
    else $error("period out of range");
endmodule : spg_pulse_gen
`default_nettype wire

// ### tb/spg_trig_src.sv
`timescale 1ns/100ps
`default_nettype none
module spg_trig_src (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic en_i,
  // trigger pin
  output logic trig_o
);
  // ------------------------------------------------------------
  // periodic trigger, 200 clocks, 40 high, low when idle
  // ------------------------------------------------------------
  int cnt_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt_ff <= 0;
      trig_o <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == 199) ? 0 : cnt_ff + 1;
      trig_o <= (cnt_ff < 40);
    end
  end
endmodule : spg_trig_src
`default_nettype wire

// ### tb/tb_single_double_pulse_generator.sv
`timescale 1ns/100ps
`default_nettype none
module tb_single_double_pulse_generator;
  import spg_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int LIM = 6000;
  logic clk_i, rst_i;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic trig, trig_en, sync, video, modd, err;
  int err_count, num_checks;

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  spg_pulse_gen i_dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .trig_i(trig), .sync_o(sync), .video_o(video), .mod_o(modd), .err_o(err)
  );

  spg_trig_src i_src (.clk_i(clk_i), .rst_i(rst_i), .en_i(trig_en), .trig_o(trig));

  // ------------------------------------------------------------
  // report and compare
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic fail(input string m);
    err_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail

  task automatic guard(input int n);
    if (n > LIM) begin
      fail("wait timed out");
      wrap_up();
    end
  endtask : guard

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) fail($sformatf("%s got %0h exp %0h", m, got, exp));
  endtask : chk_val

  task automatic chk_near(input int got, input int exp, input int tol, input string m);
    num_checks++;
    if (got < exp - tol || got > exp + tol) fail($sformatf("%s got %0d exp %0d", m, got, exp));
  endtask : chk_near

  function automatic int clks(input int ticks);
    return ticks * TICK_NS / CLK_NS;
  endfunction : clks

  function automatic logic pin(input int s);
    case (s)
      0: return sync;
      1: return video;
      2: return err;
      3: return modd;
      default: return trig;
    endcase
  endfunction : pin

  // ------------------------------------------------------------
  // bus and pin tasks
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw_p, w_p;
    n = 0;
    aw_p = 1;
    w_p = 1;
    @(posedge clk_i);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      guard(n);
      if (aw_p && awready) begin awvalid <= 1'b0; aw_p = 0; end
      if (w_p && wready) begin wvalid <= 1'b0; w_p = 0; end
    end while (!(bvalid === 1'b1 && !aw_p && !w_p));
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ar_p;
    n = 0;
    ar_p = 1;
    @(posedge clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      guard(n);
      if (ar_p && arready) begin arvalid <= 1'b0; ar_p = 0; end
    end while (!(rvalid === 1'b1 && !ar_p));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_val(32'(r), 32'(RESP_OK), "bresp");
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [1:0] r;
    logic [31:0] d;
    axi_rd(a, d, r);
    chk_val(32'(r), 32'(RESP_OK), "rresp");
    chk_val(d, e, "rdata");
  endtask : rd_chk

  task automatic wait_lvl(input int s, input logic v, output int n);
    n = 0;
    while (pin(s) !== v) begin
      @(posedge clk_i);
      n++;
      guard(n);
    end
  endtask : wait_lvl

  // sync high, sync rise to video rise, video width, video rise to next video rise
  task automatic meas(output int hs, output int dl, output int wd, output int rr);
    int n;
    wait_lvl(0, 1'b0, n);
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, hs);
    wait_lvl(1, 1'b1, n);
    dl = hs + n;
    wait_lvl(1, 1'b0, wd);
    wait_lvl(1, 1'b1, n);
    rr = wd + n;
  endtask : meas

  task automatic no_video(input int cyc, input logic vs_mod);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      if (vs_mod ? (modd !== video) : (video !== 1'b0)) bad++;
    end
    chk_val(32'(bad), 32'h0, "video watch");
  endtask : no_video

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  logic [7:0] c_adr [4] = '{OFS_PER, OFS_WID, OFS_DLY, OFS_DD};
  logic [31:0] c_in [4] = '{32'h001fffff, 32'h0, 32'h5, 32'h0};
  logic [31:0] c_exp [4] = '{32'h001e8480, 32'h1, 32'ha, 32'h2};

  initial begin
    int hs, dl, wd, rr, n;
    logic [31:0] d;
    logic [1:0] r;
    err_count = 0; num_checks = 0; rst_i = 1'b1; trig_en = 1'b0;
    awaddr = 8'h0; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
    bready = 1'b0; araddr = 8'h0; arvalid = 1'b0; rready = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_PER, 32'(RST_PER));
    rd_chk(OFS_WID, 32'(RST_WID));
    rd_chk(OFS_DLY, 32'(RST_DLY));
    rd_chk(OFS_DD, 32'(RST_DD));
    meas(hs, dl, wd, rr);
    chk_near(hs, clks(SYNC_TICKS), 1, "sync width");
    chk_near(dl, clks(int'(RST_DLY)), 2, "delay");
    chk_near(wd, clks(int'(RST_WID)), 2, "width");
    chk_near(rr, clks(int'(RST_PER)), 2, "period");
    wr(OFS_PER, 32'd40); wr(OFS_WID, 32'd4); wr(OFS_DLY, 32'd10);
    meas(hs, dl, wd, rr);
    chk_near(dl, clks(10), 2, "short delay");
    chk_near(wd, clks(4), 2, "short width");
    chk_near(rr, clks(40), 2, "short period");
    wr(OFS_WID, 32'd12); wr(OFS_PER, 32'd20);
    wait_lvl(2, 1'b1, n);
    no_video(200, 1'b0);
    axi_rd(OFS_STAT, d, r);
    chk_val(32'(r), 32'(RESP_OK), "status resp");
    chk_val(d & 32'h0000_000b, 32'h0000_0009, "status err busy");
    wr(OFS_PER, 32'd22);
    wait_lvl(2, 1'b0, n);
    meas(hs, dl, wd, rr);
    chk_near(wd, clks(12), 2, "width at edge");
    wr(OFS_WID, 32'd4); wr(OFS_PER, 32'd40); wr(OFS_CTRL, 32'h1); wr(OFS_DD, 32'd3);
    wait_lvl(2, 1'b1, n);
    no_video(120, 1'b0);
    wr(OFS_DD, 32'd8);
    wait_lvl(2, 1'b0, n);
    meas(hs, dl, wd, rr);
    chk_near(rr, clks(8), 2, "double spacing");
    chk_near(dl, clks(10), 2, "double delay");
    wr(OFS_TOG, 32'h3);
    rd_chk(OFS_CTRL, 32'h2);
    wr(OFS_TOG, 32'h2);
    rd_chk(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h2);
    trig_en <= 1'b1;
    wait_lvl(4, 1'b1, n);
    wait_lvl(0, 1'b1, n);
    chk_near(n, 4, 1, "trigger to sync");
    meas(hs, dl, wd, rr);
    chk_near(rr, 200, 1, "trigger period");
    chk_near(dl, clks(10), 2, "ext delay");
    wr(OFS_CTRL, 32'h4);
    no_video(150, 1'b1);
    wr(OFS_CTRL, 32'hc);
    wait_lvl(4, 1'b0, n);
    wait_lvl(4, 1'b1, n);
    wait_lvl(3, 1'b1, n);
    chk_near(n, 5, 1, "raw trigger to modulator");
    for (int i = 0; i < 4; i++) begin
      wr(c_adr[i], c_in[i]);
      rd_chk(c_adr[i], c_exp[i]);
    end
    axi_rd(8'h1c, d, r);
    chk_val(32'(r), 32'(RESP_SLV), "unmapped read resp");
    chk_val(d, 32'h0, "unmapped read data");
    axi_wr(8'h1c, 32'h1, r);
    chk_val(32'(r), 32'(RESP_SLV), "unmapped write resp");
    wrap_up();
  end
endmodule : tb_single_double_pulse_generator
`default_nettype wire
